// ### shared/cgd_map.svh
// Constants of the processor glue block: address map, ports, vectors, timing.
// Assumes inclusion by the cgd_glue module; definitions only.
//
// Function
// - Hold processor reset while power not good
// - Latch low address on strobe falling edge
// - Decode only the mapped parts of 64K
// - IO/memory select picks memory or I/O space
// - I/O write 0008 updates command latch
// - I/O read 0008 returns cover/paper/carrier status
// - I/O read 0009 returns communication switches
// - Printer interrupt plus vector on data lines
// - Receiver character ready drives restart 6.5
// - Vectors 0018 tick, 0028 timeout/FIFO, 0008 both
// - Periodic tick interrupt every 2.5 ms
// - Interrupt when dot FIFOs half empty
// - Halve 2 MHz crystal into 1 MHz clock
// - READY low on print controller accesses
// - Map ROM, RAM, keypad, printer, serial ranges
`ifndef CGD_MAP_SVH
`define CGD_MAP_SVH

// ****************************************
// Memory map
// ****************************************
`define CGD_ROM_LOW_FIRST 16'h0000
`define CGD_ROM_LOW_LAST 16'h0FFF
`define CGD_ROM_HIGH_FIRST 16'h1000
`define CGD_ROM_HIGH_LAST 16'h1FFF
`define CGD_RAM_FIRST 16'h2000
`define CGD_RAM_LAST 16'h23FF
`define CGD_KEYPAD_FIRST 16'h3000
`define CGD_KEYPAD_LAST 16'h300F
`define CGD_PRINT_FIRST 16'h4000
`define CGD_PRINT_LAST 16'h4003
`define CGD_SERIAL_FIRST 16'h5000
`define CGD_SERIAL_LAST 16'h5001

// ****************************************
// I/O ports and fields
// ****************************************
`define CGD_PORT_CMD_STATUS 8'h08
`define CGD_PORT_SWITCHES 8'h09
`define CGD_CMD_RESET 8'h00

// ****************************************
// Restart vectors
// ****************************************
`define CGD_VEC_RESET 16'h0000
`define CGD_VEC_COMBINED 16'h0008
`define CGD_VEC_TICK 16'h0018
`define CGD_VEC_TIMEOUT_FIFO 16'h0028
`define CGD_VEC_SIX_FIVE 16'h0034
`define CGD_RESTART_OPCODE 8'hC7

// ****************************************
// Timing
// ****************************************
`define CGD_MCLK_KHZ 25000
`define CGD_TICK_NS 2500000
`define CGD_TICK_CYC ((`CGD_TICK_NS / 1000) * `CGD_MCLK_KHZ / 1000)
`define CGD_WAIT_NS 1000
`define CGD_WAIT_CYC ((`CGD_WAIT_NS * `CGD_MCLK_KHZ + 999999) / 1000000)

`endif

// ### shared/cgd_pkg.sv
// Types of the processor glue block.
// Assumes nothing beyond a SystemVerilog compiler.
package cgd_pkg;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [4:0] servo_motion;
    logic dtr_enable;
    logic setup_lamp;
    logic power_lamp;
  } cgd_cmd_s;

  typedef struct packed {
    logic carrier_detect;
    logic paper_low;
    logic paper_out;
    logic cover_closed;
  } cgd_status_s;

  typedef struct packed {
    logic rom_low_select;
    logic rom_high_select;
    logic ram_bank_select;
    logic keypad_select;
    logic print_ctrl_select;
    logic serial_port_select;
  } cgd_sel_s;

  typedef struct packed {
    logic power_good_wake;
    logic ale;
    logic io_mem_sel;
    logic rd_n;
    logic wr_n;
    logic inta_n;
    logic xtal;
    logic rx_ready;
    logic timer_timeout;
    logic fifo_half_empty;
    cgd_status_s status;
    logic [7:0] switches;
    logic [7:0] high_address_byte;
    logic [7:0] muxed_addr_data_bus;
  } cgd_pins_s;

  typedef enum logic [1:0] {
    W_IDLE,
    W_STALL,
    W_HOLD
  } cgd_wait_e;

endpackage

// ### core/cgd_addr_latch.sv
// Low address latch on the multiplexed address/data lines.
// Assumes strobe and lines already synchronised to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module cgd_addr_latch
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ale_i,
  input wire logic [7:0] ad_i,
  output logic [7:0] low_addr_o
);

  // ****************************************
  // Follow while strobe high, freeze on fall
  // ****************************************
  logic [7:0] low_addr_q;
  logic [7:0] low_addr_d;

  assign low_addr_d = ale_i ? ad_i : low_addr_q;
  assign low_addr_o = low_addr_q;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      low_addr_q <= 8'h00;
    else
      low_addr_q <= low_addr_d;
  end

endmodule
`default_nettype wire

// ### core/cgd_tick_gen.sv
// Periodic tick pulse for the print controller interrupt.
// Assumes one clock; period given in mclk_i cycles.
`timescale 1ns/10ps
`default_nettype none
module cgd_tick_gen
#(
  parameter int unsigned TICK_CYC = 62500
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  output logic tick_o
);

  // ****************************************
  // Period counter
  // ****************************************
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic tick_q;
  logic wrap;

  assign wrap = (cnt_q == 17'(TICK_CYC - 1));
  assign cnt_d = wrap ? 17'h00000 : cnt_q + 17'h00001;
  assign tick_o = tick_q;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end

endmodule
`default_nettype wire

// ### core/cgd_glue.sv
// Processor glue: reset, address latch, decode, I/O ports, interrupts, wait states.
// Assumes processor and panel signals arrive asynchronously on pins.
`include "cgd_map.svh"
`timescale 1ns/10ps
`default_nettype none
module cgd_glue
#(
  parameter int unsigned TICK_CYC = `CGD_TICK_CYC
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic power_good_wake_i,
  input wire logic xtal_i,
  input wire logic ale_i,
  input wire logic io_mem_sel_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic inta_n_i,
  input wire logic [7:0] high_address_byte_i,
  input wire logic [7:0] muxed_addr_data_bus_i,
  input wire logic rx_ready_i,
  input wire logic timer_timeout_i,
  input wire logic fifo_half_empty_i,
  input wire cgd_pkg::cgd_status_s status_i,
  input wire logic [7:0] switches_i,
  output logic proc_reset_n_o,
  output logic clk_1mhz_o,
  output logic ready_o,
  output logic printer_ctrl_irq_o,
  output logic restart_input_six_five_o,
  output cgd_pkg::cgd_sel_s sel_o,
  output cgd_pkg::cgd_cmd_s cmd_o,
  output logic [7:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe_o
);

  // ****************************************
  // Decode function
  // ****************************************
  function automatic cgd_pkg::cgd_sel_s mem_decode(input logic [15:0] a);
    cgd_pkg::cgd_sel_s s;
    s = '0;
    s.rom_low_select = (a >= `CGD_ROM_LOW_FIRST) && (a <= `CGD_ROM_LOW_LAST);
    s.rom_high_select = (a >= `CGD_ROM_HIGH_FIRST) && (a <= `CGD_ROM_HIGH_LAST);
    s.ram_bank_select = (a >= `CGD_RAM_FIRST) && (a <= `CGD_RAM_LAST);
    s.keypad_select = (a >= `CGD_KEYPAD_FIRST) && (a <= `CGD_KEYPAD_LAST);
    s.print_ctrl_select = (a >= `CGD_PRINT_FIRST) && (a <= `CGD_PRINT_LAST);
    s.serial_port_select = (a >= `CGD_SERIAL_FIRST) && (a <= `CGD_SERIAL_LAST);
    return s;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam cgd_pkg::cgd_pins_s PINS_RST = '{
    rd_n: 1'b1, wr_n: 1'b1, inta_n: 1'b1, default: '0};

  cgd_pkg::cgd_pins_s pins_raw;
  cgd_pkg::cgd_pins_s meta_q;
  cgd_pkg::cgd_pins_s pin_q;
  cgd_pkg::cgd_pins_s prev_q;

  assign pins_raw = '{
    power_good_wake: power_good_wake_i,
    ale: ale_i,
    io_mem_sel: io_mem_sel_i,
    rd_n: rd_n_i,
    wr_n: wr_n_i,
    inta_n: inta_n_i,
    xtal: xtal_i,
    rx_ready: rx_ready_i,
    timer_timeout: timer_timeout_i,
    fifo_half_empty: fifo_half_empty_i,
    status: status_i,
    switches: switches_i,
    high_address_byte: high_address_byte_i,
    muxed_addr_data_bus: muxed_addr_data_bus_i};

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= PINS_RST;
      pin_q <= PINS_RST;
      prev_q <= PINS_RST;
    end
    else
    begin
      meta_q <= pins_raw;
      pin_q <= meta_q;
      prev_q <= pin_q;
    end
  end

  // ****************************************
  // Address latch and tick
  // ****************************************
  logic [7:0] low_addr;
  logic tick;

  cgd_addr_latch u_addr_latch
  (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ale_i(pin_q.ale),
    .ad_i(pin_q.muxed_addr_data_bus),
    .low_addr_o(low_addr)
  );

  cgd_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick_gen
  (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick)
  );

  // ****************************************
  // Cycle decode
  // ****************************************
  logic [15:0] addr;
  logic mem_cycle;
  logic io_cycle;
  logic rd_act;
  logic wr_act;
  logic inta_act;
  logic io_port_cmd;
  logic io_port_sw;
  cgd_pkg::cgd_sel_s mem_sel;
  cgd_pkg::cgd_sel_s sel_d;

  assign addr = {pin_q.high_address_byte, low_addr};
  assign rd_act = !pin_q.rd_n;
  assign wr_act = !pin_q.wr_n;
  assign inta_act = !pin_q.inta_n;
  assign mem_cycle = !pin_q.io_mem_sel && (rd_act || wr_act);
  assign io_cycle = pin_q.io_mem_sel && (rd_act || wr_act);
  assign mem_sel = mem_decode(addr);
  assign sel_d = mem_cycle ? mem_sel : '0;
  assign io_port_cmd = io_cycle && (low_addr == `CGD_PORT_CMD_STATUS);
  assign io_port_sw = io_cycle && (low_addr == `CGD_PORT_SWITCHES);

  // ****************************************
  // Command latch and status return
  // ****************************************
  cgd_pkg::cgd_cmd_s cmd_q;
  cgd_pkg::cgd_cmd_s cmd_d;

  assign cmd_d = (io_port_cmd && wr_act) ? cgd_pkg::cgd_cmd_s'(pin_q.muxed_addr_data_bus) : cmd_q;

  // ****************************************
  // Printer interrupt pending flags
  // ****************************************
  logic tick_pend_q;
  logic tick_pend_d;
  logic tof_pend_q;
  logic tof_pend_d;
  logic tof_event;
  logic inta_fall;
  logic inta_rise;
  logic [1:0] served_q;
  logic [1:0] served_d;
  logic [7:0] vector_code;

  assign tof_event = (pin_q.timer_timeout && !prev_q.timer_timeout)
    || (pin_q.fifo_half_empty && !prev_q.fifo_half_empty);
  assign inta_fall = inta_act && prev_q.inta_n;
  assign inta_rise = !inta_act && !prev_q.inta_n;
  assign served_d = inta_fall ? {tof_pend_q, tick_pend_q} : served_q;
  assign tick_pend_d = tick || (tick_pend_q && !(inta_rise && served_q[0]));
  assign tof_pend_d = tof_event || (tof_pend_q && !(inta_rise && served_q[1]));

  always_comb
  begin
    case (served_q)
      2'b11: vector_code = 8'(`CGD_RESTART_OPCODE | `CGD_VEC_COMBINED);
      2'b01: vector_code = 8'(`CGD_RESTART_OPCODE | `CGD_VEC_TICK);
      2'b10: vector_code = 8'(`CGD_RESTART_OPCODE | `CGD_VEC_TIMEOUT_FIFO);
      default: vector_code = 8'h00;
    endcase
  end

  // ****************************************
  // Data bus drive
  // ****************************************
  logic [7:0] ad_d;
  logic ad_oe_d;
  logic vec_drive;

  assign vec_drive = inta_act && !inta_fall && (served_q != 2'b00);
  assign ad_oe_d = (io_port_cmd && rd_act) || (io_port_sw && rd_act) || vec_drive;

  always_comb
  begin
    if (vec_drive)
      ad_d = vector_code;
    else if (io_port_sw)
      ad_d = pin_q.switches;
    else if (io_port_cmd)
      ad_d = {4'h0, pin_q.status};
    else
      ad_d = 8'h00;
  end

  // ****************************************
  // Wait-state logic
  // ****************************************
  cgd_pkg::cgd_wait_e wstate_q;
  cgd_pkg::cgd_wait_e wstate_d;
  logic [7:0] wcnt_q;
  logic [7:0] wcnt_d;
  logic ready_q;
  logic ready_d;
  logic print_access;

  assign print_access = (mem_cycle && mem_sel.print_ctrl_select)
    || vec_drive;

  always_comb
  begin
    wstate_d = wstate_q;
    wcnt_d = wcnt_q;
    ready_d = ready_q;
    case (wstate_q)
      cgd_pkg::W_IDLE:
      begin
        if (print_access)
        begin
          wstate_d = cgd_pkg::W_STALL;
          wcnt_d = 8'(`CGD_WAIT_CYC - 1);
          ready_d = 1'b0;
        end
      end
      cgd_pkg::W_STALL:
      begin
        if (wcnt_q == 8'h00)
        begin
          wstate_d = cgd_pkg::W_HOLD;
          ready_d = 1'b1;
        end
        else
          wcnt_d = wcnt_q - 8'h01;
      end
      cgd_pkg::W_HOLD:
      begin
        if (!rd_act && !wr_act && !inta_act)
          wstate_d = cgd_pkg::W_IDLE;
      end
      default:
      begin
        wstate_d = cgd_pkg::W_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  cgd_pkg::cgd_sel_s sel_q;
  logic reset_n_q;
  logic clk_1mhz_q;
  logic six_five_q;
  logic irq_q;
  logic [7:0] ad_q;
  logic ad_oe_q;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reset_n_q <= 1'b0;
      clk_1mhz_q <= 1'b0;
      sel_q <= '0;
      cmd_q <= `CGD_CMD_RESET;
      tick_pend_q <= 1'b0;
      tof_pend_q <= 1'b0;
      served_q <= 2'b00;
      irq_q <= 1'b0;
      six_five_q <= 1'b0;
      ad_q <= 8'h00;
      ad_oe_q <= 1'b0;
      wstate_q <= cgd_pkg::W_IDLE;
      wcnt_q <= 8'h00;
      ready_q <= 1'b1;
    end
    else
    begin
      reset_n_q <= pin_q.power_good_wake;
      if (pin_q.xtal && !prev_q.xtal)
        clk_1mhz_q <= !clk_1mhz_q;
      sel_q <= sel_d;
      cmd_q <= cmd_d;
      tick_pend_q <= tick_pend_d;
      tof_pend_q <= tof_pend_d;
      served_q <= served_d;
      irq_q <= tick_pend_d || tof_pend_d;
      six_five_q <= pin_q.rx_ready;
      ad_q <= ad_d;
      ad_oe_q <= ad_oe_d;
      wstate_q <= wstate_d;
      wcnt_q <= wcnt_d;
      ready_q <= ready_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign proc_reset_n_o = reset_n_q;
  assign clk_1mhz_o = clk_1mhz_q;
  assign ready_o = ready_q;
  assign printer_ctrl_irq_o = irq_q;
  assign restart_input_six_five_o = six_five_q;
  assign sel_o = sel_q;
  assign cmd_o = cmd_q;
  assign muxed_addr_data_bus_o = ad_q;
  assign muxed_addr_data_bus_oe_o = ad_oe_q;

endmodule
`default_nettype wire

// ### testbench/cgd_glue_chk.sv
// Port checker for the processor glue block.
// Assumes cgd_pkg compiled first; bound into cgd_glue.
`timescale 1ns/10ps
`default_nettype none
module cgd_glue_chk
#(
  parameter int unsigned TICK_CYC = 62500
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic power_good_wake_i,
  input wire logic xtal_i,
  input wire logic io_mem_sel_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic inta_n_i,
  input wire logic [7:0] high_address_byte_i,
  input wire logic rx_ready_i,
  input wire logic proc_reset_n_o,
  input wire logic clk_1mhz_o,
  input wire logic ready_o,
  input wire logic printer_ctrl_irq_o,
  input wire logic restart_input_six_five_o,
  input wire cgd_pkg::cgd_sel_s sel_o,
  input wire cgd_pkg::cgd_cmd_s cmd_o,
  input wire logic muxed_addr_data_bus_oe_o
);
  localparam int TMAX = TICK_CYC + 5;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // ****************************************
  // Assertions
  // ****************************************
  reset_hold_a: assert property (!power_good_wake_i |-> ##3 !proc_reset_n_o)
    else $error("reset released early");
  reset_run_a: assert property (power_good_wake_i [*3] |-> ##1 proc_reset_n_o)
    else $error("reset not released");
  ready_print_a: assert property ($rose(sel_o.print_ctrl_select) |-> !ready_o)
    else $error("no wait on printer access");
  ready_cause_a: assert property ($fell(ready_o) |-> sel_o.print_ctrl_select || !$past(inta_n_i, 3))
    else $error("wait without cause");
  ready_bound_a: assert property ($fell(ready_o) |-> !ready_o [*8] ##[10:25] ready_o)
    else $error("wait length wrong");
  sel_print_a: assert property ($rose(sel_o.print_ctrl_select) |->
    $past(high_address_byte_i, 3) == 8'h40 && !$past(io_mem_sel_i, 3))
    else $error("printer select wrong");
  sel_serial_a: assert property ($rose(sel_o.serial_port_select) |-> $past(high_address_byte_i, 3) == 8'h50)
    else $error("serial select wrong");
  sel_onehot_a: assert property ($onehot0(sel_o))
    else $error("several selects");
  cmd_write_a: assert property ($changed(cmd_o) |-> !$past(wr_n_i, 3) && $past(io_mem_sel_i, 3))
    else $error("command changed without write");
  oe_cause_a: assert property ($rose(muxed_addr_data_bus_oe_o) |->
    (!$past(rd_n_i, 3) && $past(io_mem_sel_i, 3)) || !$past(inta_n_i, 3))
    else $error("data driven without cause");
  rx_follow_a: assert property (restart_input_six_five_o == $past(rx_ready_i, 3))
    else $error("restart input not following");
  clk_half_a: assert property ($changed(clk_1mhz_o) |-> $past(xtal_i, 3) && !$past(xtal_i, 4))
    else $error("divided clock toggled wrongly");
  irq_tick_a: assert property ($fell(printer_ctrl_irq_o) |-> ##[1:TMAX] printer_ctrl_irq_o)
    else $error("tick missing");
endmodule
bind cgd_glue cgd_glue_chk #(.TICK_CYC(TICK_CYC)) chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .power_good_wake_i(power_good_wake_i), .xtal_i(xtal_i), .io_mem_sel_i(io_mem_sel_i), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .inta_n_i(inta_n_i), .high_address_byte_i(high_address_byte_i), .rx_ready_i(rx_ready_i),
  .proc_reset_n_o(proc_reset_n_o), .clk_1mhz_o(clk_1mhz_o), .ready_o(ready_o),
  .printer_ctrl_irq_o(printer_ctrl_irq_o), .restart_input_six_five_o(restart_input_six_five_o),
  .sel_o(sel_o), .cmd_o(cmd_o), .muxed_addr_data_bus_oe_o(muxed_addr_data_bus_oe_o));
`default_nettype wire

// ### testbench/cgd_cpu_model.sv
// Processor bus model: memory, I/O and acknowledge cycles.
// Assumes resolved data lines fed back on ad_i.
`timescale 1ns/10ps
`default_nettype none
module cgd_cpu_model
(
  input wire logic mclk_i,
  input wire logic ready_i,
  input wire logic [7:0] ad_i,
  output logic ale_o,
  output logic io_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic inta_n_o,
  output logic busy_o,
  output logic [7:0] hi_o,
  output logic [7:0] ad_o
);
  // ****************************************
  // Bus cycle
  // ****************************************
  initial
  begin
    ale_o = 1'b0;
    io_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    inta_n_o = 1'b1;
    busy_o = 1'b0;
    hi_o = 8'h00;
    ad_o = 8'h00;
  end
  // Kind 0 read, 1 write, 2 acknowledge
  task automatic bus(input logic io, input logic [15:0] a, input logic [1:0] k, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    @(posedge mclk_i);
    busy_o <= 1'b1;
    io_o <= io;
    hi_o <= a[15:8];
    ad_o <= a[7:0];
    ale_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    ale_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    ad_o <= (k == 2'd1) ? d : ~a[7:0];
    rd_n_o <= k != 2'd0;
    wr_n_o <= k != 2'd1;
    inta_n_o <= k != 2'd2;
    repeat (5) @(posedge mclk_i);
    n = 0;
    while (!ready_i && n < 60)
    begin
      @(posedge mclk_i);
      n++;
    end
    q = ad_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    inta_n_o <= 1'b1;
    ad_o <= ~ad_o;
    repeat (6) @(posedge mclk_i);
    busy_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/cgd_glue_tb.sv
// Self-checking bench for the processor glue block.
// Assumes the processor model on the bus side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module cgd_glue_tb;
  localparam int unsigned TICK = 200;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pwg = 1'b0;
  logic xtal = 1'b0;
  logic rx = 1'b0;
  logic tmo = 1'b0;
  logic fifo = 1'b0;
  cgd_pkg::cgd_status_s stat = 4'hA;
  logic [7:0] sw = 8'h5A;
  logic ale, io, rd_n, wr_n, inta_n, busy, rst_n, clk1, ready, irq, rst65, oe;
  logic [7:0] hi, cpu_ad, ad, dout, q;
  cgd_pkg::cgd_sel_s sel;
  cgd_pkg::cgd_cmd_s cmd;
  logic [6:0] acc = 7'h00;
  logic stall = 1'b0;
  logic clk1_d = 1'b0;
  int n_tog = 0;
  int errors = 0;
  int n_checks = 0;
  int xc = 0;
  int n;
  logic [15:0] addr [14] = '{16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h23FF, 16'h2400, 16'h300F,
    16'h3010, 16'h4000, 16'h4003, 16'h4004, 16'h5001, 16'h5002, 16'h8000};
  logic [6:0] exp_sel [14] = '{7'h20, 7'h10, 7'h10, 7'h08, 7'h08, 7'h00, 7'h04,
    7'h00, 7'h02, 7'h02, 7'h00, 7'h01, 7'h00, 7'h00};
  logic [7:0] vec [3] = '{8'hDF, 8'hEF, 8'hCF};
  assign ad = oe ? dout : cpu_ad;
  always #20 mclk_i = ~mclk_i;
  // ****************************************
  // Crystal and cycle monitor
  // ****************************************
  always @(posedge mclk_i)
  begin
    xc <= (xc == 5) ? 0 : xc + 1;
    if (xc == 5)
      xtal <= ~xtal;
    acc <= busy ? (acc | {oe, sel}) : 7'h00;
    stall <= busy ? (stall | !ready) : 1'b0;
    clk1_d <= clk1;
    if (clk1 != clk1_d)
      n_tog <= n_tog + 1;
  end
  cgd_glue #(.TICK_CYC(TICK)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .power_good_wake_i(pwg),
    .xtal_i(xtal), .ale_i(ale), .io_mem_sel_i(io), .rd_n_i(rd_n), .wr_n_i(wr_n), .inta_n_i(inta_n),
    .high_address_byte_i(hi), .muxed_addr_data_bus_i(ad), .rx_ready_i(rx), .timer_timeout_i(tmo),
    .fifo_half_empty_i(fifo), .status_i(stat), .switches_i(sw), .proc_reset_n_o(rst_n),
    .clk_1mhz_o(clk1), .ready_o(ready), .printer_ctrl_irq_o(irq), .restart_input_six_five_o(rst65),
    .sel_o(sel), .cmd_o(cmd), .muxed_addr_data_bus_o(dout), .muxed_addr_data_bus_oe_o(oe));
  cgd_cpu_model cpu (.mclk_i(mclk_i), .ready_i(ready), .ad_i(ad), .ale_o(ale), .io_o(io), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .inta_n_o(inta_n), .busy_o(busy), .hi_o(hi), .ad_o(cpu_ad));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input logic i, input logic [15:0] a, input logic [1:0] k, input logic [7:0] d,
    input logic [6:0] e);
    cpu.bus(i, a, k, d, q);
    chk("selects", {1'b0, e}, {1'b0, acc});
    chk("stall", {7'h00, e[1] || k == 2'd2}, {7'h00, stall});
  endtask
  task automatic complete_run;
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk("reset", 8'h00, {7'h00, rst_n});
    chk("ready", 8'h01, {7'h00, ready});
    pwg <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk("reset", 8'h01, {7'h00, rst_n});
    n = n_tog;
    repeat (48) @(posedge mclk_i);
    chk("clk1mhz", 8'h04, 8'(n_tog - n));
    foreach (addr[i])
      cyc(1'b0, addr[i], 2'd0, 8'h00, exp_sel[i]);
    cyc(1'b1, 16'h0808, 2'd1, 8'hA5, 7'h00);
    chk("command", 8'hA5, cmd);
    cyc(1'b1, 16'h0909, 2'd1, 8'h3C, 7'h00);
    chk("command", 8'hA5, cmd);
    cyc(1'b0, 16'h0008, 2'd1, 8'h3C, 7'h20);
    chk("command", 8'hA5, cmd);
    cyc(1'b1, 16'h0808, 2'd0, 8'h00, 7'h40);
    chk("status", {4'h0, stat}, q);
    cyc(1'b1, 16'h0909, 2'd0, 8'h00, 7'h40);
    chk("switches", sw, q);
    rx <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk("rst65", 8'h01, {7'h00, rst65});
    rx <= 1'b0;
    cyc(1'b1, 16'h0000, 2'd2, 8'h00, 7'h40);
    for (int v = 0; v < 3; v++)
    begin
      n = 0;
      while (!irq && n < 300)
      begin
        @(posedge mclk_i);
        n++;
      end
      chk("irq", 8'h01, {7'h00, irq});
      cyc(1'b1, 16'h0000, 2'd2, 8'h00, 7'h40);
      chk("vector", vec[v], q);
      if (v == 0)
        fifo <= 1'b1;
      else
        tmo <= 1'b1;
      repeat (4) @(posedge mclk_i);
      fifo <= 1'b0;
      tmo <= 1'b0;
      if (v == 1)
        repeat (TICK) @(posedge mclk_i);
    end
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
